/* File: hdl/gpp_regs.svh */
// Purpose: register map, field positions and reset values of the gpio port block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   port base = port index * 0x20, register word = kind index * 4
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define GPP_NUM_PORTS     4
`define GPP_PORT_W        8
`define GPP_ADDR_W        8
`define GPP_PORT_MSB      6
`define GPP_PORT_LSB      5
`define GPP_KIND_MSB      4
`define GPP_KIND_LSB      2

// ----------------------------------------
// register word index inside a port
// ----------------------------------------
`define GPP_IDX_DIR       3'h0
`define GPP_IDX_PIN       3'h1
`define GPP_IDX_LAT       3'h2
`define GPP_IDX_ANALOG_SELECT_BIT     3'h3
`define GPP_IDX_WPU       3'h4

// ----------------------------------------
// reset values and port options
// ----------------------------------------
`define GPP_DIR_RST       8'hff
`define GPP_LAT_RST       8'h00
`define GPP_ANALOG_SELECT_BIT_RST     8'hff
`define GPP_WPU_RST       8'h00
`define GPP_HAS_ANALOG_SELECT_BIT     4'h3
`define GPP_HAS_WPU       4'h2

`endif

/* File: hdl/gpp_pkg.sv */
// Purpose: shared types of the gpio port block
// Assumes: nothing beyond the register header
// Notes:   decode result travels as one struct
package gpp_pkg;

   // ----------------------------------------
   // register kinds and decode result
   // ----------------------------------------
   typedef enum logic [2:0] {
      GPP_K_DIR,
      GPP_K_PIN,
      GPP_K_LAT,
      GPP_K_ANALOG_SELECT_BIT,
      GPP_K_WPU,
      GPP_K_NONE
   } gpp_kind_t;

   typedef struct packed {
      logic       hit;
      logic [1:0] port;
      gpp_kind_t  kind;
   } gpp_dec_t;

endpackage

/* File: hdl/gpp_pad_if.sv */
// Purpose: carries port settings to the pad stage and pad state back
// Assumes: all ports flattened, port p on bits [p*8 +: 8]
// Notes:   ctrl side is the register file, pad side the pin logic
`timescale 1ns/1ps
interface gpp_pad_if #(
   parameter int W = 32
);
   logic [W-1:0] lat;
   logic [W-1:0] dir;
   logic [W-1:0] analog_select_bit;
   logic [W-1:0] wpu;
   logic [W-1:0] p_en;
   logic [W-1:0] p_out;
   logic [W-1:0] p_drv;
   logic [W-1:0] pin_in;
   logic [W-1:0] pin_digital;
   logic [W-1:0] pin_out;
   logic [W-1:0] pin_oe_n;
   logic [W-1:0] pin_pullup;
   logic [W-1:0] pin_analog;

   modport ctrl (
      output lat, dir, analog_select_bit, wpu, p_en, p_out, p_drv, pin_in,
      input  pin_digital, pin_out, pin_oe_n, pin_pullup, pin_analog
   );
   modport pad (
      input  lat, dir, analog_select_bit, wpu, p_en, p_out, p_drv, pin_in,
      output pin_digital, pin_out, pin_oe_n, pin_pullup, pin_analog
   );
endinterface

/* File: hdl/gpp_pad.sv */
// Purpose: per-pin output mux, driver enable, pull-up and input gating
// Assumes: pin_in synchronous to pclk
// Notes:   pin_out, pin_oe_n, pin_pullup and pin_analog registered, so pins follow settings one cycle later; pin_digital is combinational
`timescale 1ns/1ps
module gpp_pad
   import gpp_pkg::*;
#(
   parameter int W = 32
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   gpp_pad_if.pad   pads
);
   `include "gpp_regs.svh"

   logic [W-1:0] drive;
   logic [W-1:0] out_reg;
   logic [W-1:0] oe_n_reg;
   logic [W-1:0] pull_reg;
   logic [W-1:0] anlg_reg;

   // ----------------------------------------
   // driver selection
   // ----------------------------------------
   // a peripheral owns its pin: the port latch and direction no longer drive it
   always_comb begin
      drive = (pads.p_en & pads.p_drv) | (~pads.p_en & ~pads.dir);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_reg  <= '0;
         oe_n_reg <= '1;
      end else if (ce) begin
         out_reg  <= (pads.p_en & pads.p_out) | (~pads.p_en & pads.lat);
         oe_n_reg <= ~drive;
      end
   end

   // pull-up only on undriven digital pins, never fighting the driver
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pull_reg <= '0;
         anlg_reg <= '1;
      end else if (ce) begin
         pull_reg <= pads.wpu & ~drive & ~pads.analog_select_bit;
         anlg_reg <= pads.analog_select_bit;
      end
   end

   // ----------------------------------------
   // input path
   // ----------------------------------------
   // pin stays readable even when a peripheral drives it
   assign pads.pin_digital = pads.pin_in & ~pads.analog_select_bit;
   assign pads.pin_out     = out_reg;
   assign pads.pin_oe_n    = oe_n_reg;
   assign pads.pin_pullup  = pull_reg;
   assign pads.pin_analog  = anlg_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_periph_owns_pin: assert property (
      ce |=> (out_reg == (($past(pads.p_en) & $past(pads.p_out)) | (~$past(pads.p_en) & $past(pads.lat)))))
      else $error("pin output does not follow owner");

   chk_dir_sets_driver: assert property (
      ce && (pads.p_en == '0) |=> (oe_n_reg == $past(pads.dir)))
      else $error("driver enable does not follow direction");

   chk_analog_reads_zero: assert property (
      ce |=> (anlg_reg == $past(pads.analog_select_bit)) && ((pads.pin_digital & pads.analog_select_bit) == '0))
      else $error("analog pin reads nonzero");

endmodule

/* File: hdl/gpp_port.sv */
// Purpose: four eight-bit general-purpose io ports behind an apb slave
// Assumes: pin inputs synchronous to pclk; ce low freezes all state
// Notes:   zero wait state apb, pslverr on unmapped or misaligned words
//
// What this block does
// - An enabled peripheral takes the pin away from the port output while the pin level stays readable.
// - Every port has a direction register, a pin-level register and an output-latch register.
// - Selected ports also carry an analog-select register, a weak pull-up register, or both.
// - Writing the pin-level register updates the output latch exactly like writing the latch register.
// - The latch register reads back the latch and the pin-level register reads the pins themselves.
// - A set analog-select bit disables the digital input buffer of its pin.
// - A direction bit at one makes the pin an input and at zero an output.
// - There are four ports, first, second, third and fourth, each with its own register set.
`timescale 1ns/1ps
`include "gpp_regs.svh"
module gpp_port
   import gpp_pkg::*;
#(
   parameter int         NUM_PORTS = `GPP_NUM_PORTS,
   parameter int         ADDR_W    = `GPP_ADDR_W,
   parameter logic [3:0] HAS_ANALOG_SELECT_BIT = `GPP_HAS_ANALOG_SELECT_BIT,
   parameter logic [3:0] HAS_WPU   = `GPP_HAS_WPU
)(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ce,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [8*NUM_PORTS-1:0] pin_in,
   input  wire logic [8*NUM_PORTS-1:0] periph_en,
   input  wire logic [8*NUM_PORTS-1:0] periph_out,
   input  wire logic [8*NUM_PORTS-1:0] periph_drive,
   output logic      [8*NUM_PORTS-1:0] pin_out,
   output logic      [8*NUM_PORTS-1:0] pin_oe_n,
   output logic      [8*NUM_PORTS-1:0] pin_pullup,
   output logic      [8*NUM_PORTS-1:0] pin_analog
);

   localparam int W = 8 * NUM_PORTS;

   logic [7:0]  dir_reg   [NUM_PORTS];
   logic [7:0]  lat_reg   [NUM_PORTS];
   logic [7:0]  analog_select_bit_reg [NUM_PORTS];
   logic [7:0]  wpu_reg   [NUM_PORTS];
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic [31:0] rd_next;
   logic [7:0]  wdata_b;
   logic        setup_cyc;
   logic        wr_fire;
   gpp_dec_t    dec;

   gpp_pad_if #(.W(W)) pads ();

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // absent optional registers decode as unmapped so software sees pslverr
   function automatic gpp_dec_t decode(input logic [ADDR_W-1:0] a);
      gpp_dec_t d;
      d.hit  = 1'b0;
      d.port = a[`GPP_PORT_MSB:`GPP_PORT_LSB];
      d.kind = GPP_K_NONE;
      if (a[1:0] == 2'h0 && a[ADDR_W-1:`GPP_PORT_MSB+1] == '0) begin
         unique case (a[`GPP_KIND_MSB:`GPP_KIND_LSB])
            `GPP_IDX_DIR:   d.kind = GPP_K_DIR;
            `GPP_IDX_PIN:   d.kind = GPP_K_PIN;
            `GPP_IDX_LAT:   d.kind = GPP_K_LAT;
            `GPP_IDX_ANALOG_SELECT_BIT: d.kind = HAS_ANALOG_SELECT_BIT[d.port] ? GPP_K_ANALOG_SELECT_BIT : GPP_K_NONE;
            `GPP_IDX_WPU:   d.kind = HAS_WPU[d.port] ? GPP_K_WPU : GPP_K_NONE;
            default:        d.kind = GPP_K_NONE;
         endcase
         d.hit = (d.kind != GPP_K_NONE) && (int'(d.port) < NUM_PORTS);
      end
      return d;
   endfunction

   function automatic logic wr_hit(input gpp_dec_t d, input int p, input gpp_kind_t k);
      return d.hit && (d.port == 2'(p)) && (d.kind == k);
   endfunction

   always_comb begin
      dec       = decode(paddr);
      wdata_b   = pwdata[7:0];
      setup_cyc = ce && psel && !penable && !pready_reg;
      wr_fire   = ce && psel && penable && pready_reg && pwrite && pstrb[0];
   end

   // ----------------------------------------
   // register file
   // ----------------------------------------
   // inputs at reset so nothing is driven before software decides
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            dir_reg[p] <= `GPP_DIR_RST;
         end
      end else if (wr_fire) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_hit(dec, p, GPP_K_DIR)) begin
               dir_reg[p] <= wdata_b;
            end
         end
      end
   end

   // pin-level and latch writes both land in the latch; pins are never written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            lat_reg[p] <= `GPP_LAT_RST;
         end
      end else if (wr_fire) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_hit(dec, p, GPP_K_LAT) || wr_hit(dec, p, GPP_K_PIN)) begin
               lat_reg[p] <= wdata_b;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            analog_select_bit_reg[p] <= HAS_ANALOG_SELECT_BIT[p] ? `GPP_ANALOG_SELECT_BIT_RST : 8'h00;
         end
      end else if (wr_fire) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_hit(dec, p, GPP_K_ANALOG_SELECT_BIT)) begin
               analog_select_bit_reg[p] <= wdata_b;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            wpu_reg[p] <= `GPP_WPU_RST;
         end
      end else if (wr_fire) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_hit(dec, p, GPP_K_WPU)) begin
               wpu_reg[p] <= wdata_b;
            end
         end
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   // read data is captured at the setup edge, so the pin value is one cycle old
   always_comb begin
      rd_next = 32'h0000_0000;
      if (dec.hit) begin
         unique case (dec.kind)
            GPP_K_DIR:   rd_next = {24'h00_0000, dir_reg[dec.port]};
            GPP_K_PIN:   rd_next = {24'h00_0000, pads.pin_digital[{dec.port, 3'h0} +: 8]};
            GPP_K_LAT:   rd_next = {24'h00_0000, lat_reg[dec.port]};
            GPP_K_ANALOG_SELECT_BIT: rd_next = {24'h00_0000, analog_select_bit_reg[dec.port]};
            GPP_K_WPU:   rd_next = {24'h00_0000, wpu_reg[dec.port]};
            GPP_K_NONE:  rd_next = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // apb answer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else if (ce) begin
         if (setup_cyc) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= ~dec.hit;
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
         end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
         end
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------
   // pad stage
   // ----------------------------------------
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_flat
      assign pads.lat[p*8 +: 8]   = lat_reg[p];
      assign pads.dir[p*8 +: 8]   = dir_reg[p];
      assign pads.analog_select_bit[p*8 +: 8] = analog_select_bit_reg[p];
      assign pads.wpu[p*8 +: 8]   = wpu_reg[p];
   end

   assign pads.p_en   = periph_en;
   assign pads.p_out  = periph_out;
   assign pads.p_drv  = periph_drive;
   assign pads.pin_in = pin_in;

   gpp_pad #(.W(W)) u_pad (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .pads    (pads.pad)
   );

   assign pin_out    = pads.pin_out;
   assign pin_oe_n   = pads.pin_oe_n;
   assign pin_pullup = pads.pin_pullup;
   assign pin_analog = pads.pin_analog;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [7:0] pin_first;
   assign pin_first = pads.pin_digital[7:0];

   sequence s_setup;
      setup_cyc;
   endsequence

   sequence s_pin_write_third;
      wr_fire && wr_hit(dec, 2, GPP_K_PIN);
   endsequence

   sequence s_lat_read_first;
      s_setup ##0 (!pwrite && wr_hit(dec, 0, GPP_K_LAT));
   endsequence

   sequence s_pin_read_first;
      s_setup ##0 (!pwrite && wr_hit(dec, 0, GPP_K_PIN));
   endsequence

   chk_apb_one_wait: assert property (
      s_setup |=> pready_reg ##1 (!pready_reg || !ce))
      else $error("apb answer not one cycle after setup");

   chk_pin_write_latch: assert property (
      s_pin_write_third |=> (lat_reg[2] == $past(wdata_b)))
      else $error("pin-level write did not reach latch");

   chk_latch_readback: assert property (
      s_lat_read_first |=> pready_reg && (prdata_reg == {24'h00_0000, lat_reg[0]}))
      else $error("latch read returns wrong value");

   chk_pin_readback: assert property (
      s_pin_read_first |=> pready_reg && (prdata_reg[7:0] == $past(pin_first)))
      else $error("pin read returns wrong value");

   chk_unmapped_error: assert property (
      s_setup ##0 !dec.hit |=> pslverr_reg && pready_reg && (prdata_reg == 32'h0000_0000))
      else $error("unmapped access not flagged");

   chk_upper_bits_zero: assert property (
      pready_reg |-> (prdata_reg[31:8] == 24'h00_0000))
      else $error("read data above bit 7 not zero");

   chk_absent_analog_select_bit: assert property (
      HAS_ANALOG_SELECT_BIT[2] || (analog_select_bit_reg[2] == 8'h00))
      else $error("absent analog select not zero");

   sequence s_dir_write_second;
      wr_fire && wr_hit(dec, 1, GPP_K_DIR);
   endsequence

   chk_dir_write: assert property (
      s_dir_write_second |=> (dir_reg[1] == $past(wdata_b)))
      else $error("direction write lost");

   chk_fourth_latch: assert property (
      wr_fire && wr_hit(dec, 3, GPP_K_LAT) |=> (lat_reg[3] == $past(wdata_b)))
      else $error("fourth port latch write lost");

   // only byte lane zero carries register data, so a write without it is dropped
   chk_strobe_masked: assert property (
      ce && psel && penable && pready_reg && pwrite && !pstrb[0] |=> $stable(lat_reg[2]))
      else $error("masked write changed the latch");

   // a frozen block must not finish or retract a bus answer on its own
   chk_ce_freeze: assert property (
      !ce |=> ($stable(pready_reg) && $stable(pslverr_reg) && $stable(prdata_reg)))
      else $error("bus answer moved while frozen");

endmodule

/* File: verification/gpp_board.sv */
// Purpose: board model behind the gpio pins
// Assumes: pin outputs registered on pclk
// Notes:   undriven, unpulled pins with no external source float and toggle
`timescale 1ns/1ps
module gpp_board (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe_n,
   input  wire logic [31:0] pin_pullup,
   input  wire logic [31:0] ext_en,
   input  wire logic [31:0] ext_val,
   output logic      [31:0] pin_in
);
   // ----------------------------------------
   // floating level
   // ----------------------------------------
   logic [31:0] flt_reg;

   // a floating pin must not look like a stable value, so it flips each cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flt_reg <= 32'h00000000;
      end else begin
         flt_reg <= ~flt_reg;
      end
   end

   // ----------------------------------------
   // wire level
   // ----------------------------------------
   assign pin_in = (~pin_oe_n & pin_out)
                 | (pin_oe_n & ext_en & ext_val)
                 | (pin_oe_n & ~ext_en & (pin_pullup | flt_reg));
endmodule

/* File: verification/gpp_port_tb.sv */
// Purpose: self-checking bench of the gpio port block
// Assumes: apb slave answers in its own time, pins looped through the board model
// Notes:   ce dropped once near the end to check that pin outputs freeze
`timescale 1ns/1ps
module gpp_port_tb
   import gpp_pkg::*;
;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        pclk         = 1'b0;
   logic        presetn      = 1'b0;
   logic        ce           = 1'b1;
   logic        psel         = 1'b0;
   logic        penable      = 1'b0;
   logic        pwrite       = 1'b0;
   logic [7:0]  paddr        = 8'h00;
   logic [31:0] pwdata       = 32'h00000000;
   logic [3:0]  pstrb        = 4'h0;
   logic [31:0] periph_en    = 32'h00000000;
   logic [31:0] periph_out   = 32'h00000000;
   logic [31:0] periph_drive = 32'h00000000;
   logic [31:0] ext_en       = 32'hffffffff;
   logic [31:0] ext_val      = 32'h3c96e14b;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] pin_in;
   logic [31:0] pin_out;
   logic [31:0] pin_oe_n;
   logic [31:0] pin_pullup;
   logic [31:0] pin_analog;
   logic [31:0] rd;
   logic        er;
   logic [7:0]  e;
   logic [7:0]  bad [6] = '{8'h4c, 8'h10, 8'h6c, 8'h81, 8'h14, 8'h80};
   int          num_errors = 0;
   int          tests_run  = 0;

   always #10 pclk = ~pclk;

   gpp_port dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .periph_en(periph_en),
      .periph_out(periph_out), .periph_drive(periph_drive), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .pin_analog(pin_analog));

   gpp_board board (.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      chk({24'h000000, got}, {24'h000000, exp});
   endtask

   // request held from setup until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      pstrb   <= st;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h000000, d}, 4'hf);
   endtask

   task automatic rc(input logic [7:0] a, input logic [7:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h00000000, 4'h0);
      chk(rd, {24'h000000, exp});
      chk({31'h00000000, er}, {31'h00000000, exp_err});
   endtask

   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   function automatic logic [7:0] adr(input int p, input int k);
      return 8'(p * 32 + k * 4);
   endfunction

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk(pin_oe_n, 32'hffffffff);
      chk(pin_analog, 32'h0000ffff);
      chk(pin_pullup, 32'h00000000);
      for (int p = 0; p < 4; p++) begin
         rc(adr(p, 0), 8'hff, 1'b0);
         rc(adr(p, 2), 8'h00, 1'b0);
         if (p < 2) rc(adr(p, 3), 8'hff, 1'b0);
      end
      rc(adr(1, 4), 8'h00, 1'b0);
      foreach (bad[i]) rc(bad[i], 8'h00, 1'b1);
      apb(1'b1, 8'h4c, 32'h000000ff, 4'hf);
      chk({31'h00000000, er}, 32'h00000001);
      wr(adr(0, 3), 8'h00);
      wr(adr(1, 3), 8'h00);
      for (int p = 0; p < 4; p++) begin
         e = 8'h5a ^ 8'(p * 17);
         wr(adr(p, 2), e);
         wr(adr(p, 0), 8'h0f);
         rc(adr(p, 2), e, 1'b0);
         settle();
         chk8(pin_oe_n[p*8+:8], 8'h0f);
         chk8(pin_out[p*8+:8], e);
         rc(adr(p, 1), (e & 8'hf0) | (ext_val[p*8+:8] & 8'h0f), 1'b0);
      end
      wr(adr(2, 1), 8'h33);
      rc(adr(2, 2), 8'h33, 1'b0);
      apb(1'b1, adr(2, 2), 32'h000000cc, 4'he);
      rc(adr(2, 2), 8'h33, 1'b0);
      // analog pins 0..3 of the first port read zero
      wr(adr(0, 3), 8'h0f);
      settle();
      chk8(pin_analog[7:0], 8'h0f);
      rc(adr(0, 1), 8'h5a & 8'hf0, 1'b0);
      // second port: no external source, pull-up on undriven pins only
      ext_en[15:8] <= 8'h00;
      wr(adr(1, 4), 8'hff);
      settle();
      chk8(pin_pullup[15:8], 8'h0f);
      rc(adr(1, 1), 8'h4b & 8'hf0 | 8'h0f, 1'b0);
      // peripheral takes the fourth port, drives pins 0..3 only
      periph_en[31:24]    <= 8'hff;
      periph_drive[31:24] <= 8'h0f;
      periph_out[31:24]   <= 8'ha5;
      settle();
      chk8(pin_oe_n[31:24], 8'hf0);
      chk8(pin_out[31:24], 8'ha5);
      rc(adr(3, 1), 8'h05 | (ext_val[31:24] & 8'hf0), 1'b0);
      rc(adr(3, 2), 8'h5a ^ 8'h33, 1'b0);
      // clock enable low: a new peripheral value must wait for ce
      ce                <= 1'b0;
      periph_out[31:24] <= 8'h5a;
      settle();
      chk8(pin_out[31:24], 8'ha5);
      @(posedge pclk);
      ce <= 1'b1;
      settle();
      chk8(pin_out[31:24], 8'h5a);
      close_out();
   end

   initial begin
      repeat (6000) @(posedge pclk);
      num_errors++;
      close_out();
   end
endmodule
